// *** common/dcc_map.vh ***
`ifndef DCC_MAP_VH
`define DCC_MAP_VH
// Special-function-register decode
`define DCC_CFG_ADDR      8'h96
`define DCC_CFG_PAGE      4'h0
`define DCC_MODE_ADDR     8'h94
`define DCC_MODE_PAGE     4'hF
// Configuration register fields
`define DCC_CFG_LOW_POWER_ENABLE_BIT  7
`define DCC_CFG_DIV_HI    6
`define DCC_CFG_DIV_LO    5
`define DCC_CFG_SARPOL    4
`define DCC_CFG_INV_BIT   3
`define DCC_CFG_ILIM_BIT  2
`define DCC_CFG_SLP_BIT   1
`define DCC_CFG_SRC_BIT   0
`define DCC_CFG_RESET     8'h00
// Mode register fields
`define DCC_MODE_FLG_BIT  3
`define DCC_MODE_BYP_HI   2
`define DCC_MODE_BYP_LO   1
`define DCC_MODE_PAS_BIT  0
`define DCC_MODE_RESET    3'h0
// Bypass select encodings
`define DCC_BYP_OFF       2'h0
`define DCC_BYP_AUTO_OSC  2'h1
`define DCC_BYP_AUTO_LOW  2'h2
`define DCC_BYP_FORCE     2'h3
`endif

// *** core/dcc_sync2.v ***
`timescale 1ns/1ps
module dcc_sync2
(
  input  wire clock,
  input  wire rst_n,
  input  wire din,
  output wire dout
);
  reg stage1_q;
  reg stage2_q;

  // Two-stage synchroniser
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
    end
    else
    begin
      stage1_q <= din;
      stage2_q <= stage1_q;
    end
  end

  assign dout = stage2_q;
endmodule // dcc_sync2

// *** core/dcc_clkgen.v ***
`timescale 1ns/1ps
module dcc_clkgen
(
  input  wire       clock,
  input  wire       rst_n,
  input  wire [1:0] divSel,
  input  wire       invert,
  output wire       convClk,
  output wire       phaseWrap
);
  reg  [2:0] cnt_q;
  reg  [2:0] cnt_d;
  reg  [1:0] sel_q;
  reg        inv_q;
  reg        clk_q;
  reg        clk_d;
  wire [2:0] half;
  wire       divByOne;

  // Half period in system clocks, selector registered at falling toggles, or every clock in divide-by-one
  assign half     = (sel_q == 2'h1) ? 3'h1 : (sel_q == 2'h2) ? 3'h2 : 3'h4;
  assign divByOne = (sel_q == 2'h0);

  // Divider: counts toward a toggle; new settings load only at a falling toggle, or every clock in divide-by-one
  always @*
  begin
    cnt_d = cnt_q + 3'h1;
    clk_d = clk_q;
    if (divByOne)
    begin
      cnt_d = 3'h0;
    end
    else if (cnt_q + 3'h1 >= half)
    begin
      cnt_d = 3'h0;
      clk_d = ~clk_q;
    end
  end

  // Settings change only as the divided clock falls to complete a cycle, or on every clock in divide-by-one
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 3'h0;
      clk_q <= 1'b0;
      sel_q <= 2'h0;
      inv_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      clk_q <= clk_d;
      if (divByOne || (clk_q && !clk_d))
      begin
        sel_q <= divSel;
        inv_q <= invert;
      end
    end
  end

  // Divide-by-one passes the (optionally inverted) system clock itself
  assign convClk   = divByOne ? (clock ^ inv_q) : (clk_q ^ inv_q);
  assign phaseWrap = divByOne | (clk_q & ~clk_d);
endmodule // dcc_clkgen

// *** core/dcc_config_ctrl.v ***
`timescale 1ns/1ps
`include "dcc_map.vh"
// Functional notes
// - Config bit 7 drives low-power mode
// - Bits 6:5 divide system clock 1/2/4/8
// - Divider ignored on local oscillator
// - Bit 4 zero inverts SAR clock
// - SAR polarity ignored without sync
// - Bit 3 inverts system clock at divider output
// - Bit 2 picks peak current threshold
// - Bit 1 floats output in sleep
// - Bit 0 picks system or local clock
// - Mode bits 7:4 read zero, ignore writes
// - Mode bit 3 reads live bypass state
// - Bypass 00 off, 11 forced
// - Bypass 01/10 auto, oscillator on/off
// - Mode bit 0 enables passive diode
// - Config 0x96 page 0, mode 0x94 page F
// - Sync enable aligns SAR clock to converter
module dcc_config_ctrl
(
  input  wire       clock,
  input  wire       rst_n,
  input  wire [7:0] sfrAddr,
  input  wire [3:0] sfrPage,
  input  wire       sfrWrite,
  input  wire       sfrRead,
  input  wire [7:0] sfrWdata,
  output reg  [7:0] sfrRdata,
  output wire       sfrHit,
  input  wire       syncEnable,
  input  wire       localOscClk,
  input  wire       bypassActive,
  output wire       lowPowerEnable,
  output wire       peakCurrentThreshold,
  output wire       sleepOutputFloat,
  output wire       convClockSource,
  output reg        convClk,
  output wire       sarClk,
  output wire       sarSyncPulse,
  output wire       bypassEnable,
  output wire       bypassForce,
  output wire       convOscEnable,
  output wire       passiveDiodeEnable
);
  reg  [7:0] cfg_q;
  reg  [2:0] mode_q;
  reg        srcSel_q;
  reg        locPrev_q;
  reg        sysPrev_q;
  wire       cfgHit;
  wire       modeHit;
  wire       sysDivClk;
  wire       sysWrap;
  wire       locSync;
  wire       bypSync;
  wire       locRise;
  wire       sysRise;
  wire [1:0] bypSel;

  // Register decode on address and page
  assign cfgHit  = (sfrAddr == `DCC_CFG_ADDR) && (sfrPage == `DCC_CFG_PAGE);
  assign modeHit = (sfrAddr == `DCC_MODE_ADDR) && (sfrPage == `DCC_MODE_PAGE);
  assign sfrHit  = cfgHit | modeHit;

  // Register writes
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_q  <= `DCC_CFG_RESET;
      mode_q <= `DCC_MODE_RESET;
    end
    else
    begin
      if (sfrWrite && cfgHit)
      begin
        cfg_q <= sfrWdata;
      end
      if (sfrWrite && modeHit)
      begin
        mode_q <= {sfrWdata[`DCC_MODE_BYP_HI:`DCC_MODE_BYP_LO],
                   sfrWdata[`DCC_MODE_PAS_BIT]};
      end
    end
  end

  // Bypass status from the analog stage is asynchronous
  dcc_sync2 uBypSync
  (
    .clock (clock),
    .rst_n (rst_n),
    .din   (bypassActive),
    .dout  (bypSync)
  );

  // Local oscillator sampled for switchover timing and SAR sync pulses
  dcc_sync2 uLocSync
  (
    .clock (clock),
    .rst_n (rst_n),
    .din   (localOscClk),
    .dout  (locSync)
  );

  // Read mux; unmapped addresses read zero
  always @*
  begin
    sfrRdata = 8'h00;
    if (sfrRead && cfgHit)
    begin
      sfrRdata = cfg_q;
    end
    else if (sfrRead && modeHit)
    begin
      sfrRdata = {4'h0, bypSync, mode_q};
    end
  end

  // Static controls to the power stage
  assign lowPowerEnable       = cfg_q[`DCC_CFG_LOW_POWER_ENABLE_BIT];
  assign peakCurrentThreshold = cfg_q[`DCC_CFG_ILIM_BIT];
  assign sleepOutputFloat     = cfg_q[`DCC_CFG_SLP_BIT];
  assign convClockSource      = srcSel_q;
  assign bypSel               = mode_q[2:1];
  assign bypassEnable         = (bypSel != `DCC_BYP_OFF);
  assign bypassForce          = (bypSel == `DCC_BYP_FORCE);
  assign convOscEnable        = (bypSel != `DCC_BYP_AUTO_LOW);
  assign passiveDiodeEnable   = mode_q[0];

  // System-clock divider with inversion
  dcc_clkgen uClkGen
  (
    .clock     (clock),
    .rst_n     (rst_n),
    .divSel    (cfg_q[`DCC_CFG_DIV_HI:`DCC_CFG_DIV_LO]),
    .invert    (cfg_q[`DCC_CFG_INV_BIT]),
    .convClk   (sysDivClk),
    .phaseWrap (sysWrap)
  );

  // Edge trackers for the two candidate clocks
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      locPrev_q <= 1'b0;
      sysPrev_q <= 1'b0;
    end
    else
    begin
      locPrev_q <= locSync;
      sysPrev_q <= sysDivClk;
    end
  end

  assign locRise = locSync & ~locPrev_q;
  assign sysRise = sysWrap;

  // Source changes only at a cycle boundary of the clock being left
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      srcSel_q <= 1'b0;
    end
    else if (cfg_q[`DCC_CFG_SRC_BIT] != srcSel_q)
    begin
      if ((srcSel_q && sysRise) || (!srcSel_q && locRise))
      begin
        srcSel_q <= cfg_q[`DCC_CFG_SRC_BIT];
      end
    end
  end

  // Output clock mux; divider only reaches it when system clock chosen
  always @*
  begin
    convClk = localOscClk;
    if (srcSel_q)
    begin
      convClk = sysDivClk;
    end
  end

  // SAR clock polarity applies only with sync enabled
  assign sarClk = (syncEnable && !cfg_q[`DCC_CFG_SARPOL]) ? ~convClk : convClk;
  assign sarSyncPulse = syncEnable & (srcSel_q ? sysRise : locRise);
endmodule // dcc_config_ctrl

// *** verif/dcc_analog_model.sv ***
`timescale 1ns/1ps
module dcc_analog_model
(
  input  wire bypassEnable,
  input  wire bypassForce,
  input  wire convOscEnable,
  input  wire vinHigh,
  output reg  localOscClk,
  output wire bypassActive
);
  initial localOscClk = 1'b0;
  // Local oscillator stands low while disabled
  always #17 localOscClk = (convOscEnable === 1'b1) ? !localOscClk : 1'b0;
  // Bypass when forced, or automatic with a high input
  assign bypassActive = bypassForce | (bypassEnable & vinHigh);
endmodule // dcc_analog_model

// *** verif/dcc_config_ctrl_checker.sv ***
`timescale 1ns/1ps
`include "dcc_map.vh"
module dcc_config_ctrl_checker
(
  input wire       clock,
  input wire       rst_n,
  input wire [7:0] sfrAddr,
  input wire [3:0] sfrPage,
  input wire       sfrWrite,
  input wire       sfrRead,
  input wire [7:0] sfrWdata,
  input wire [7:0] sfrRdata,
  input wire       syncEnable,
  input wire       convClk,
  input wire       sarClk,
  input wire       lowPowerEnable,
  input wire       peakCurrentThreshold,
  input wire       sleepOutputFloat,
  input wire       bypassForce,
  input wire       convOscEnable,
  input wire       passiveDiodeEnable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Write decodes
  wire cfgW = sfrWrite && sfrAddr == `DCC_CFG_ADDR && sfrPage == `DCC_CFG_PAGE;
  wire modeW = sfrWrite && sfrAddr == `DCC_MODE_ADDR && sfrPage == `DCC_MODE_PAGE;
  AST_LP: assert property (cfgW |=> lowPowerEnable == $past(sfrWdata[7]))
    else $error("low power bit mismatch");
  AST_ILIM: assert property (cfgW |=> peakCurrentThreshold == $past(sfrWdata[2]))
    else $error("current threshold mismatch");
  AST_SLP: assert property (cfgW |=> sleepOutputFloat == $past(sfrWdata[1]))
    else $error("sleep float mismatch");
  AST_FORCE: assert property (modeW |=> bypassForce == ($past(sfrWdata[2:1]) == 2'h3))
    else $error("bypass force mismatch");
  AST_OSC: assert property (modeW |=> convOscEnable == ($past(sfrWdata[2:1]) != 2'h2))
    else $error("oscillator enable mismatch");
  AST_PAS: assert property (modeW |=> passiveDiodeEnable == $past(sfrWdata[0]))
    else $error("passive diode mismatch");
  AST_HI: assert property (sfrRead && modeW == 0 && sfrAddr == `DCC_MODE_ADDR
    && sfrPage == `DCC_MODE_PAGE |-> sfrRdata[7:4] == 4'h0)
    else $error("mode upper bits not zero");
  AST_SAR: assert property (!syncEnable |-> sarClk == convClk)
    else $error("sar clock altered without sync");
  COV_CFG: cover property (cfgW ##1 lowPowerEnable);
  COV_FORCE: cover property (modeW ##1 bypassForce);
  COV_SYNC: cover property (syncEnable && sarClk != convClk);
endmodule // dcc_config_ctrl_checker

// *** verif/dcc_config_ctrl_tb.sv ***
`timescale 1ns/1ps
module dcc_config_ctrl_tb;
  reg        clock = 0;
  reg        rst_n = 0;
  reg  [7:0] sfrAddr = 0;
  reg  [3:0] sfrPage = 0;
  reg        sfrWrite = 0;
  reg        sfrRead = 0;
  reg  [7:0] sfrWdata = 0;
  reg        syncEnable = 0;
  reg        vinHigh = 0;
  reg  [7:0] c, m, rd;
  wire [7:0] sfrRdata;
  wire       lOsc, bAct, lowP, peakC, slpF, convClk, sarClk, bEn, bFrc, oscEn, pasEn;
  wire       hit, src, sPulse;
  reg        hitRd;
  integer    num_errors = 0, check_count = 0, cyc = 0, cc = 0, lc = 0, i, sp = 0;
  integer    seed = 32'h1a94_3ae3;
  // Clock, edge counters and hang guard
  always #5 clock = ~clock;
  always @(posedge convClk) cc = cc + 1;
  always @(posedge lOsc) lc = lc + 1;
  always @(posedge clock) if (sPulse === 1'b1) sp = sp + 1;
  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      num_errors = num_errors + 1;
      report_and_stop;
    end
  end
  dcc_config_ctrl uut (.clock(clock), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrPage(sfrPage),
    .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
    .sfrHit(hit), .syncEnable(syncEnable), .localOscClk(lOsc), .bypassActive(bAct),
    .lowPowerEnable(lowP), .peakCurrentThreshold(peakC), .sleepOutputFloat(slpF),
    .convClockSource(src), .convClk(convClk), .sarClk(sarClk), .sarSyncPulse(sPulse),
    .bypassEnable(bEn), .bypassForce(bFrc), .convOscEnable(oscEn), .passiveDiodeEnable(pasEn));
  dcc_analog_model ana (.bypassEnable(bEn), .bypassForce(bFrc), .convOscEnable(oscEn),
    .vinHigh(vinHigh), .localOscClk(lOsc), .bypassActive(bAct));
  function [7:0] expMode(input [7:0] v);
    expMode = {4'h0, v[2:1] == 2'h3 || (v[2:1] != 2'h0 && v[7]), v[2:0]};
  endfunction
  task check(input [7:0] got, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // One register cycle, read data taken mid-cycle
  task acc(input w, input [11:0] a, input [7:0] d);
    begin
      @(posedge clock);
      sfrWrite <= w;
      sfrRead <= !w;
      {sfrPage, sfrAddr} <= a;
      sfrWdata <= d;
      @(negedge clock);
      rd = sfrRdata;
      hitRd = hit;
      @(posedge clock);
      sfrWrite <= 0;
      sfrRead <= 0;
    end
  endtask
  task report_and_stop;
    begin
      $display("checks=%0d errors=%0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clock);
    rst_n <= 1;
    acc(0, 12'hF96, 0);
    check(rd, 8'h00);
    check(hitRd, 1'b0);
    acc(0, 12'hF94, 0);
    check(hitRd, 1'b1);
    for (i = 0; i < 40; i = i + 1)
    begin
      c = $random(seed);
      m = $random(seed);
      vinHigh <= m[7];
      acc(1, 12'h096, c);
      acc(1, 12'hF94, m);
      repeat (3) @(posedge clock);
      acc(0, 12'h096, 0);
      check(rd, c);
      check({lowP, peakC, slpF}, {c[7], c[2], c[1]});
      acc(0, 12'hF94, 0);
      check(rd, expMode(m));
      check({bEn, bFrc, oscEn, pasEn}, {m[2:1] != 0, m[2:1] == 3, m[2:1] != 2, m[0]});
    end
    $display("register test done");
    acc(1, 12'hF94, 0);
    for (i = 0; i < 5; i = i + 1)
    begin
      acc(1, 12'h096, i < 4 ? {1'b0, i[1:0], 1'b0, i[0], 3'h1} : 8'h60);
      repeat (30) @(posedge clock);
      cc = 0;
      lc = 0;
      repeat (64) @(posedge clock);
      check(src, i < 4);
      if (i == 4)
        check(cc >= lc - 1 && cc <= lc + 1, 1);
      else
        check(cc >= (64 >> i) - 1 && cc <= (64 >> i) + 1, 1);
    end
    $display("clock test done");
    syncEnable <= 1;
    acc(1, 12'h096, 8'h21);
    repeat (8) @(posedge clock);
    sp = 0;
    repeat (8) @(posedge clock);
    check(sp >= 3 && sp <= 5, 1);
    @(negedge clock);
    check(sarClk, !convClk);
    @(posedge clock);
    syncEnable <= 0;
    @(negedge clock);
    check(sarClk, convClk);
    $display("sync test done");
    report_and_stop;
  end
endmodule // dcc_config_ctrl_tb
bind dcc_config_ctrl dcc_config_ctrl_checker chk (.clock(clock), .rst_n(rst_n),
  .sfrAddr(sfrAddr), .sfrPage(sfrPage), .sfrWrite(sfrWrite), .sfrRead(sfrRead),
  .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .syncEnable(syncEnable), .convClk(convClk),
  .sarClk(sarClk), .lowPowerEnable(lowPowerEnable), .peakCurrentThreshold(peakCurrentThreshold),
  .sleepOutputFloat(sleepOutputFloat), .bypassForce(bypassForce),
  .convOscEnable(convOscEnable), .passiveDiodeEnable(passiveDiodeEnable));
